// file: include/i2crp_pkg.sv
/*
 Constants, state and kind types shared by both ends of the two-wire
 register read path. Assumes one 40 MHz system clock on both ends.
*/
// What this block does
// - master writes address then zero-mode pointer byte
// - device acks address and pointer on ninth
// - repeated start, read address, device sends register
// - read bits valid at rising serial clock
// - pointer advances after every second byte
// - stop accepted anywhere, read ends cleanly
// - pointer kept across stop
// - past last register reads all ones
// - master acks every read byte but last
// - master ends read with nack then stop
// - master waits after supply up before talking
// - pointer is six low bits of byte
// - address select pin picks one of two
// - increment past end parks at out-of-range value
package i2crp_pkg;
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          SCL_HZ         = 400_000;
    localparam int          SCL_QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
    localparam int          POWERUP_MS     = 150;
    localparam int          POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_MS;

    localparam int          PTR_W          = 8;
    localparam int          IDX_W          = 6;
    localparam int          WORD_W         = 16;
    localparam int          BYTE_W         = 8;
    localparam int          NUM_REGS       = 47;
    localparam logic [6:0]  DEV_ADDR_LOW   = 7'h74;
    localparam logic [6:0]  DEV_ADDR_HIGH  = 7'h75;
    localparam logic [7:0]  LAST_REG_IDX   = 8'h2e;
    localparam logic [7:0]  PTR_PAST_END   = 8'hff;
    localparam logic [7:0]  PTR_RESET      = 8'h00;
    localparam logic [7:0]  DUMMY_BYTE     = 8'hff;
    localparam logic [1:0]  MODE_NORMAL    = 2'h0;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    typedef enum logic [2:0] {
        DS_IDLE     = 3'b000,
        DS_ADDR     = 3'b001,
        DS_ADDR_ACK = 3'b010,
        DS_PTR      = 3'b011,
        DS_PTR_ACK  = 3'b100,
        DS_TX       = 3'b101,
        DS_TX_ACK   = 3'b110,
        DS_IGNORE   = 3'b111
    } i2crp_dev_state_type;

    typedef enum logic [2:0] {
        MS_PWR   = 3'b000,
        MS_IDLE  = 3'b001,
        MS_START = 3'b010,
        MS_TX    = 3'b011,
        MS_RX    = 3'b100,
        MS_STOP  = 3'b101
    } i2crp_mst_state_type;

    typedef enum logic [1:0] {
        BK_ADDR_W = 2'b00,
        BK_PTR    = 2'b01,
        BK_ADDR_R = 2'b10
    } i2crp_kind_type;
endpackage : i2crp_pkg

// file: include/i2crp_bus_if.sv
/*
 Two-wire bus between the master end and the device end.
 Assumes both ends drive SDA open-drain only; SCL is driven by the master.
*/
`timescale 1ns/10ps
`default_nettype none
interface i2crp_bus_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire  sda;

    // pulled up unless an enabled driver pulls low
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
    modport device (input scl, output sda_s_o, output sda_s_oe, input sda);
endinterface : i2crp_bus_if
`default_nettype wire

// file: verilog/i2crp_device.sv
/*
 Device end of the register read path: address match, pointer load,
 two-byte register readout with auto-increment.
 Assumes the master keeps SCL low/high phases well above four clk_sys cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module i2crp_device (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           nrst,
    // serial bus
    i2crp_bus_if.device                         bus,
    // strap
    input  wire logic                           slave_address_select_pin,
    // register contents load
    input  wire logic                           reg_wr_en,
    input  wire logic [i2crp_pkg::IDX_W-1:0]    reg_wr_index,
    input  wire logic [i2crp_pkg::WORD_W-1:0]   reg_wr_data,
    // status
    output logic      [i2crp_pkg::PTR_W-1:0]    pointer_value,
    output logic                                read_active
);
    import i2crp_pkg::*;

    i2crp_dev_state_type state_reg;
    logic [2:0]          scl_sync_reg;
    logic [2:0]          sda_sync_reg;
    logic [1:0]          asel_sync_reg;
    logic [BYTE_W-1:0]   shift_reg;
    logic [3:0]          bit_cnt_reg;
    logic                rw_reg;
    logic                master_ack_reg;
    logic                sda_oe_reg;
    logic [PTR_W-1:0]    ptr_reg;
    logic [PTR_W-1:0]    ptr_next;
    logic                byte_sel_reg;
    logic [WORD_W-1:0]   regs_mem [NUM_REGS];
    logic [BYTE_W-1:0]   cur_byte;
    logic [6:0]          own_addr;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_seen;
    logic                stop_seen;
    logic                byte_sent;
    logic                ptr_load;

    // stage 0 of each chain feeds only stage 1
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_sync_reg  <= 3'h7;
            sda_sync_reg  <= 3'h7;
            asel_sync_reg <= 2'h0;
        end else begin
            scl_sync_reg  <= {scl_sync_reg[1:0], bus.scl};
            sda_sync_reg  <= {sda_sync_reg[1:0], bus.sda};
            asel_sync_reg <= {asel_sync_reg[0], slave_address_select_pin};
        end
    end

    assign scl_rise   = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall   = ~scl_sync_reg[1] & scl_sync_reg[2];
    assign start_seen = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_sync_reg[1];
    assign stop_seen  = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_sync_reg[1];
    assign own_addr   = asel_sync_reg[1] ? DEV_ADDR_HIGH : DEV_ADDR_LOW;

    assign byte_sent  = (state_reg == DS_TX) & scl_fall & (bit_cnt_reg == BITS_PER_BYTE);
    assign ptr_load   = (state_reg == DS_PTR) & scl_fall & (bit_cnt_reg == BITS_PER_BYTE)
                        & (shift_reg[7:6] == MODE_NORMAL);

    // high byte of the word goes out first
    always_comb begin
        cur_byte = DUMMY_BYTE;
        if (ptr_reg <= LAST_REG_IDX) begin
            cur_byte = byte_sel_reg ? regs_mem[ptr_reg[IDX_W-1:0]][BYTE_W-1:0]
                                    : regs_mem[ptr_reg[IDX_W-1:0]][WORD_W-1:BYTE_W];
        end
    end

    // once past the last register the pointer parks until rewritten
    assign ptr_next = (ptr_reg >= LAST_REG_IDX) ? PTR_PAST_END : ptr_reg + 8'h01;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_mem[i] <= REG_RESET;
            end
        end else if (reg_wr_en && (reg_wr_index <= LAST_REG_IDX[IDX_W-1:0])) begin
            regs_mem[reg_wr_index] <= reg_wr_data;
        end
    end

    // pointer and byte half; stop or start clears the byte half, the pointer is kept
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ptr_reg      <= PTR_RESET;
            byte_sel_reg <= 1'b0;
        end else if (start_seen || stop_seen) begin
            byte_sel_reg <= 1'b0;
        end else if (ptr_load) begin
            ptr_reg      <= {MODE_NORMAL, shift_reg[IDX_W-1:0]};
            byte_sel_reg <= 1'b0;
        end else if (byte_sent) begin
            byte_sel_reg <= ~byte_sel_reg;
            if (byte_sel_reg) begin
                ptr_reg <= ptr_next;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg      <= DS_IDLE;
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 4'h0;
            rw_reg         <= 1'b0;
            master_ack_reg <= 1'b0;
            sda_oe_reg     <= 1'b0;
        end else if (stop_seen) begin
            state_reg  <= DS_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg   <= DS_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                DS_IDLE, DS_IGNORE: begin
                end
                DS_ADDR, DS_PTR: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && (bit_cnt_reg == BITS_PER_BYTE)) begin
                        if (state_reg == DS_PTR) begin
                            state_reg  <= DS_PTR_ACK;
                            sda_oe_reg <= 1'b1;
                        end else if (shift_reg[7:1] == own_addr) begin
                            rw_reg     <= shift_reg[0];
                            state_reg  <= DS_ADDR_ACK;
                            sda_oe_reg <= 1'b1;
                        end else begin
                            state_reg <= DS_IGNORE;
                        end
                    end
                end
                DS_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            state_reg   <= DS_TX;
                            shift_reg   <= cur_byte;
                            sda_oe_reg  <= ~cur_byte[7];
                            bit_cnt_reg <= 4'h1;
                        end else begin
                            state_reg   <= DS_PTR;
                            sda_oe_reg  <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                        end
                    end
                end
                DS_PTR_ACK: begin
                    // data bytes of a write belong to the write path, not here
                    if (scl_fall) begin
                        state_reg  <= DS_IGNORE;
                        sda_oe_reg <= 1'b0;
                    end
                end
                DS_TX: begin
                    // new bit set just after the fall so it is settled at the rise
                    if (scl_fall) begin
                        if (bit_cnt_reg == BITS_PER_BYTE) begin
                            state_reg  <= DS_TX_ACK;
                            sda_oe_reg <= 1'b0;
                        end else begin
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg  <= ~shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                DS_TX_ACK: begin
                    if (scl_rise) begin
                        master_ack_reg <= ~sda_sync_reg[1];
                    end else if (scl_fall) begin
                        if (master_ack_reg) begin
                            state_reg   <= DS_TX;
                            shift_reg   <= cur_byte;
                            sda_oe_reg  <= ~cur_byte[7];
                            bit_cnt_reg <= 4'h1;
                        end else begin
                            state_reg <= DS_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    assign bus.sda_s_o    = 1'b0;
    assign bus.sda_s_oe   = sda_oe_reg;
    assign pointer_value  = ptr_reg;
    assign read_active    = (state_reg == DS_TX) | (state_reg == DS_TX_ACK);
endmodule : i2crp_device
`default_nettype wire

// file: verilog/i2crp_master.sv
/*
 Master end: waits out supply settling, then runs pointer-set plus read
 frames. Assumes a device that never stretches SCL.
*/
`timescale 1ns/10ps
`default_nettype none
module i2crp_master #(
    parameter int POWERUP_CYCLES_P = i2crp_pkg::POWERUP_CYCLES,
    parameter int QTR_CYCLES_P     = i2crp_pkg::SCL_QTR_CYCLES
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // serial bus
    i2crp_bus_if.master                        bus,
    // command
    input  wire logic                          cmd_valid,
    output logic                               cmd_ready,
    input  wire logic                          cmd_set_ptr,
    input  wire logic [i2crp_pkg::IDX_W-1:0]   cmd_ptr,
    input  wire logic                          cmd_addr_sel,
    input  wire logic [7:0]                    cmd_len,
    // answers
    output logic      [i2crp_pkg::BYTE_W-1:0]  rd_data,
    output logic                               rd_valid,
    output logic                               done,
    output logic                               addr_nack
);
    import i2crp_pkg::*;

    localparam int PWR_W = $clog2(POWERUP_CYCLES_P + 1);
    localparam int DIV_W = $clog2(QTR_CYCLES_P + 1);

    i2crp_mst_state_type state_reg;
    i2crp_kind_type      kind_reg;
    logic [PWR_W-1:0]    pwr_cnt_reg;
    logic                pwr_done;
    logic [DIV_W-1:0]    div_cnt_reg;
    logic                tick;
    logic [1:0]          sda_sync_reg;
    logic [1:0]          qtr_reg;
    logic [3:0]          bit_cnt_reg;
    logic [BYTE_W-1:0]   tx_shift_reg;
    logic [BYTE_W-1:0]   rx_shift_reg;
    logic [7:0]          remain_reg;
    logic                set_ptr_reg;
    logic [IDX_W-1:0]    ptr_reg;
    logic [6:0]          addr_reg;
    logic                ack_bad_reg;
    logic                scl_reg;
    logic                sda_oe_reg;

    assign pwr_done = (pwr_cnt_reg == PWR_W'(POWERUP_CYCLES_P));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwr_cnt_reg <= '0;
        end else if (!pwr_done) begin
            pwr_cnt_reg <= pwr_cnt_reg + PWR_W'(1);
        end
    end

    // quarter-bit enable; idle so frames always start on a fresh quarter
    assign tick = (div_cnt_reg == DIV_W'(QTR_CYCLES_P - 1));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_cnt_reg <= '0;
        end else if ((state_reg == MS_IDLE) || (state_reg == MS_PWR) || tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sda_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], bus.sda};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= MS_PWR;
            kind_reg     <= BK_ADDR_W;
            qtr_reg      <= 2'h0;
            bit_cnt_reg  <= 4'h0;
            tx_shift_reg <= 8'h00;
            rx_shift_reg <= 8'h00;
            remain_reg   <= 8'h00;
            set_ptr_reg  <= 1'b0;
            ptr_reg      <= 6'h00;
            addr_reg     <= DEV_ADDR_LOW;
            ack_bad_reg  <= 1'b0;
            scl_reg      <= 1'b1;
            sda_oe_reg   <= 1'b0;
            rd_data      <= 8'h00;
            rd_valid     <= 1'b0;
            done         <= 1'b0;
            addr_nack    <= 1'b0;
        end else begin
            rd_valid  <= 1'b0;
            done      <= 1'b0;
            addr_nack <= 1'b0;
            unique case (state_reg)
                MS_PWR: begin
                    if (pwr_done) begin
                        state_reg <= MS_IDLE;
                    end
                end
                MS_IDLE: begin
                    if (cmd_valid) begin
                        set_ptr_reg <= cmd_set_ptr;
                        ptr_reg     <= cmd_ptr;
                        addr_reg    <= cmd_addr_sel ? DEV_ADDR_HIGH : DEV_ADDR_LOW;
                        remain_reg  <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                        qtr_reg     <= 2'h0;
                        state_reg   <= MS_START;
                    end
                end
                MS_START: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        unique case (qtr_reg)
                            2'h0: begin
                                sda_oe_reg <= 1'b0;
                                scl_reg    <= 1'b0;
                            end
                            2'h1: scl_reg    <= 1'b1;
                            2'h2: sda_oe_reg <= 1'b1;
                            2'h3: begin
                                scl_reg      <= 1'b0;
                                bit_cnt_reg  <= 4'h0;
                                state_reg    <= MS_TX;
                                kind_reg     <= set_ptr_reg ? BK_ADDR_W : BK_ADDR_R;
                                tx_shift_reg <= {addr_reg, ~set_ptr_reg};
                            end
                        endcase
                    end
                end
                MS_TX: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        unique case (qtr_reg)
                            2'h0: begin
                                scl_reg    <= 1'b0;
                                sda_oe_reg <= (bit_cnt_reg < BITS_PER_BYTE) & ~tx_shift_reg[7];
                            end
                            2'h1: scl_reg <= 1'b1;
                            2'h2: ack_bad_reg <= sda_sync_reg[1];
                            2'h3: begin
                                scl_reg <= 1'b0;
                                if (bit_cnt_reg < BITS_PER_BYTE) begin
                                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                                    bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                                end else if (ack_bad_reg) begin
                                    addr_nack <= 1'b1;
                                    state_reg <= MS_STOP;
                                end else begin
                                    bit_cnt_reg <= 4'h0;
                                    unique case (kind_reg)
                                        BK_ADDR_W: begin
                                            kind_reg     <= BK_PTR;
                                            tx_shift_reg <= {MODE_NORMAL, ptr_reg};
                                        end
                                        BK_PTR: begin
                                            set_ptr_reg <= 1'b0;
                                            state_reg   <= MS_START;
                                        end
                                        default: state_reg <= MS_RX;
                                    endcase
                                end
                            end
                        endcase
                    end
                end
                MS_RX: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        unique case (qtr_reg)
                            2'h0: begin
                                scl_reg    <= 1'b0;
                                sda_oe_reg <= (bit_cnt_reg == BITS_PER_BYTE)
                                              & (remain_reg != 8'h01);
                            end
                            2'h1: scl_reg <= 1'b1;
                            2'h2: begin
                                if (bit_cnt_reg < BITS_PER_BYTE) begin
                                    rx_shift_reg <= {rx_shift_reg[6:0], sda_sync_reg[1]};
                                end
                            end
                            2'h3: begin
                                scl_reg <= 1'b0;
                                if (bit_cnt_reg < BITS_PER_BYTE) begin
                                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                end else begin
                                    rd_data     <= rx_shift_reg;
                                    rd_valid    <= 1'b1;
                                    bit_cnt_reg <= 4'h0;
                                    remain_reg  <= remain_reg - 8'h01;
                                    if (remain_reg == 8'h01) begin
                                        state_reg <= MS_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                end
                MS_STOP: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        unique case (qtr_reg)
                            2'h0: begin
                                scl_reg    <= 1'b0;
                                sda_oe_reg <= 1'b1;
                            end
                            2'h1: scl_reg    <= 1'b1;
                            2'h2: sda_oe_reg <= 1'b0;
                            2'h3: begin
                                done      <= 1'b1;
                                state_reg <= MS_IDLE;
                            end
                        endcase
                    end
                end
                default: state_reg <= MS_IDLE;
            endcase
        end
    end

    assign cmd_ready    = (state_reg == MS_IDLE);
    assign bus.scl      = scl_reg;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = sda_oe_reg;
endmodule : i2crp_master
`default_nettype wire

// file: tb/i2crp_asserts.sv
/*
 Checker for the two-wire link between master and device ends.
 Assumes it sees the interface signals as plain inputs, one clk_sys domain.
*/
`timescale 1ns/10ps
`default_nettype none
module i2crp_asserts #(
    parameter int PWR_P = 100
) (
    // link signals
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic sda
);
    int unsigned up_cnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // saturates so a long run cannot wrap it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            up_cnt <= 0;
        else if (up_cnt < PWR_P)
            up_cnt <= up_cnt + 1;
    end
    chk_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    chk_dev_oe_steady: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("device changed sda while scl high");
    chk_ack_whole: assert property ($rose(scl) && sda_s_oe |-> !sda [*8])
        else $error("device low level not held over the pulse");
    chk_one_driver: assert property (scl && sda_s_oe |-> !sda_m_oe)
        else $error("master drives sda during a device bit");
    chk_powerup_wait: assert property ($fell(scl) |-> up_cnt >= PWR_P - 1)
        else $error("bus used before power-up delay");
    chk_stop_quiet: assert property ($rose(sda) && scl && $past(scl) |-> !sda_s_oe [*8])
        else $error("device drives sda after stop");
    chk_start_quiet: assert property ($fell(sda) && scl && $past(scl) |-> !sda_s_oe [*8])
        else $error("device drives sda after start");
    cover property ($fell(sda) && scl);
    cover property ($rose(scl) && sda_s_oe);
    cover property ($rose(sda) && scl);
endmodule : i2crp_asserts
`default_nettype wire

// file: tb/i2c_register_read_path_test.sv
/*
 Bench: master and device joined by the bus interface, driven through the
 master command port. Assumes a 40 MHz clock and shortened power-up delay.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_register_read_path_test;
    import i2crp_pkg::*;
    logic        clk_sys, nrst, strap, wr_en, c_valid, c_set, c_sel, c_ready, rval, dn, anack;
    logic        ract, half;
    logic [5:0]  wr_idx, c_ptr;
    logic [15:0] wr_data, w;
    logic [7:0]  c_len, pv, rdat, ep;
    int          errors = 0, num_checks = 0, cyc = 0;
    i2crp_bus_if bus ();
    i2crp_master #(.POWERUP_CYCLES_P(100), .QTR_CYCLES_P(25)) i2crp_master_inst (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .cmd_valid(c_valid), .cmd_ready(c_ready),
        .cmd_set_ptr(c_set), .cmd_ptr(c_ptr), .cmd_addr_sel(c_sel), .cmd_len(c_len),
        .rd_data(rdat), .rd_valid(rval), .done(dn), .addr_nack(anack));
    i2crp_device i2crp_device_inst (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
        .slave_address_select_pin(strap), .reg_wr_en(wr_en), .reg_wr_index(wr_idx),
        .reg_wr_data(wr_data), .pointer_value(pv), .read_active(ract));
    i2crp_asserts #(.PWR_P(100)) i2crp_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
        .scl(bus.scl), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .sda(bus.sda));
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] word(input logic [5:0] i);
        return {2'h0, i, 2'h2, ~i};
    endfunction : word
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    // pointer and byte half are tracked here from the rules alone
    task automatic run(input logic set, input logic [5:0] p, input logic sel,
                       input logic [7:0] n, input logic bad);
        int   got = 0;
        logic na = 1'h0;
        while (c_ready !== 1'h1)
            @(negedge clk_sys);
        {c_valid, c_set, c_ptr, c_sel, c_len} = {1'h1, set, p, sel, n};
        if (set && !bad)
            ep = {2'h0, p};
        half = 1'h0;
        @(negedge clk_sys);
        c_valid = 1'h0;
        while (dn !== 1'h1) begin
            @(negedge clk_sys);
            na = na | (anack === 1'h1);
            if (rval === 1'h1) begin
                got++;
                check({15'h0, ract}, 16'h1);
                w = ep > 8'h2e ? 16'hffff : word(ep[5:0]);
                check({8'h0, rdat}, {8'h0, half ? w[7:0] : w[15:8]});
                if (half)
                    ep = ep >= 8'h2e ? 8'hff : ep + 8'h1;
                half = ~half;
            end
        end
        check(got[15:0], bad ? 16'h0 : {8'h0, n});
        check({15'h0, na}, {15'h0, bad});
        check({8'h0, pv}, {8'h0, ep});
        check({14'h0, bus.sda_s_oe, ract}, 16'h0);
    endtask : run
    task automatic t_walk();
        run(1'h1, 6'h03, 1'h0, 8'h05, 1'h0);
    endtask : t_walk
    task automatic t_resume();
        run(1'h0, 6'h00, 1'h0, 8'h03, 1'h0);
    endtask : t_resume
    task automatic t_end();
        strap = 1'h1;
        run(1'h1, 6'h2d, 1'h1, 8'h07, 1'h0);
    endtask : t_end
    task automatic t_wrong();
        run(1'h1, 6'h10, 1'h0, 8'h02, 1'h1);
    endtask : t_wrong
    task automatic t_high();
        run(1'h1, 6'h3f, 1'h1, 8'h03, 1'h0);
    endtask : t_high
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        {nrst, strap, wr_en, c_valid, c_set, c_sel, wr_idx, c_ptr, wr_data, c_len} = '0;
        repeat (20) @(negedge clk_sys);
        nrst = 1'h1;
        for (int i = 0; i < NUM_REGS; i++) begin
            {wr_en, wr_idx, wr_data} = {1'h1, i[5:0], word(i[5:0])};
            @(negedge clk_sys);
        end
        wr_en = 1'h0;
        check({15'h0, c_ready}, 16'h0);
        t_walk();
        t_resume();
        t_end();
        t_wrong();
        t_high();
        finish_test();
    end
endmodule : i2c_register_read_path_test
`default_nettype wire
